// >>> core/mcsm_pkg.sv
// package for the motor controller operating state machine
// assumes a single 20 MHz clock domain
package mcsm_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   // switch-release hold time before alert may clear
   localparam int unsigned RELEASE_HOLD_MS = 2000;
   localparam int unsigned RELEASE_HOLD_CYC = (RELEASE_HOLD_MS * (CLK_HZ / 1000)) + 1;
   // under-voltage must persist this long before it counts; plain default, set per product
   localparam int unsigned UNDERVOLT_DELAY_MS = 1000;
   localparam int unsigned UNDERVOLT_DELAY_CYC = UNDERVOLT_DELAY_MS * (CLK_HZ / 1000);
   // standby measurement period
   localparam int unsigned MEAS_PERIOD_MS = 10;
   localparam int unsigned MEAS_PERIOD_CYC = MEAS_PERIOD_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 32;
   localparam logic [1:0] RESET_STATE_CODE = 2'h0;
   typedef enum logic [1:0] {
      MCSM_HIBERNATE,
      MCSM_STANDBY,
      MCSM_ACTIVE,
      MCSM_ALERT
   } mcsm_state_e;
endpackage

// >>> core/mcsm_hold_timer.sv
// hold timer: counts cycles a qualifying level stays high, flags when limit reached
// assumes synchronous inputs and active-high synchronous reset
`timescale 1ns/10ps
module mcsm_hold_timer
   import mcsm_pkg::*;
#(
   parameter logic [CNT_W-1:0] LIMIT = 32'h00000001
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic level,
   output logic done
);
   logic [CNT_W-1:0] count;

   // any drop of the level restarts the count
   always_ff @(posedge sys_clk) begin
      if (reset || !level) begin
         count <= '0;
      end else if (count != LIMIT) begin
         count <= count + 32'h00000001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || !level) begin
         done <= 1'b0;
      end else begin
         done <= (count == LIMIT - 32'h00000001) || (count == LIMIT);
      end
   end
endmodule // mcsm_hold_timer

// >>> core/mcsm_top.sv
// operating state machine: hibernate, standby, active, alert
// assumes protection detectors and the switch are synchronous to sys_clk
`timescale 1ns/10ps
// Function
// - hibernate halts measurement and drive entirely
// - standby issues a periodic measurement strobe and acts on results
// - active allows motor drive; the measurement strobe is issued only in standby
// - alert drops drive first, then holds the alert output
// - active entered only with no protection asserted
// - any protection while active forces alert
// - alert leaves after switch released over two seconds, re-press restarts
// - below power-on-reset threshold always goes to hibernate
// - under-voltage held past its delay is a protection cutting drive
module mcsm_top
   import mcsm_pkg::*;
#(
   parameter int unsigned RELEASE_CYC = RELEASE_HOLD_CYC,
   parameter int unsigned UNDERVOLT_CYC = UNDERVOLT_DELAY_CYC,
   parameter int unsigned MEAS_CYC = MEAS_PERIOD_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic below_por,
   input wire logic below_discharge,
   input wire logic over_current,
   input wire logic over_temp,
   input wire logic switch_pressed,
   input wire logic drive_request,
   output logic drive_enable,
   output logic alert_out,
   output logic measure_strobe,
   output logic measure_enable,
   output logic under_voltage_protect,
   output logic [1:0] state_code
);
   mcsm_state_e state;
   mcsm_state_e next_state;
   logic release_done;
   logic undervolt_done;
   logic any_protect;
   logic [CNT_W-1:0] meas_count;

   // last count of a measurement period; the counter never runs past it
   function automatic logic meas_last(input logic [CNT_W-1:0] value);
      return value == CNT_W'(MEAS_CYC) - 32'h00000001;
   endfunction

   mcsm_hold_timer #(.LIMIT(CNT_W'(RELEASE_CYC))) u_release (
      .sys_clk(sys_clk),
      .reset(reset),
      .level(state == MCSM_ALERT && !switch_pressed),
      .done(release_done)
   );

   mcsm_hold_timer #(.LIMIT(CNT_W'(UNDERVOLT_CYC))) u_undervolt (
      .sys_clk(sys_clk),
      .reset(reset),
      .level(below_discharge && state != MCSM_HIBERNATE),
      .done(undervolt_done)
   );

   assign any_protect = undervolt_done || over_current || over_temp;

   always_comb begin
      next_state = state;
      case (state)
         MCSM_HIBERNATE: begin
            if (!below_por) begin
               next_state = MCSM_STANDBY;
            end
         end
         MCSM_STANDBY: begin
            if (switch_pressed && !any_protect) begin
               next_state = MCSM_ACTIVE;
            end
         end
         MCSM_ACTIVE: begin
            if (any_protect) begin
               next_state = MCSM_ALERT;
            end else if (!switch_pressed) begin
               next_state = MCSM_STANDBY;
            end
         end
         MCSM_ALERT: begin
            // done is registered and lags a re-press by one edge, so check the switch too
            if (release_done && !switch_pressed && !any_protect) begin
               next_state = MCSM_STANDBY;
            end
         end
         default: begin
            next_state = MCSM_HIBERNATE;
         end
      endcase
      if (below_por) begin
         next_state = MCSM_HIBERNATE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= MCSM_HIBERNATE;
      end else begin
         state <= next_state;
      end
   end

   // drive follows next state so alert entry cuts it the same edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         drive_enable <= 1'b0;
      end else begin
         drive_enable <= (next_state == MCSM_ACTIVE) && drive_request;
      end
   end

   // alert raised one edge after drive drops, so drive is off first
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         alert_out <= 1'b0;
      end else begin
         alert_out <= (state == MCSM_ALERT) && (next_state == MCSM_ALERT);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         under_voltage_protect <= 1'b0;
      end else begin
         under_voltage_protect <= undervolt_done;
      end
   end

   // measurement period counter idles in hibernate to save power
   always_ff @(posedge sys_clk) begin
      if (reset || state == MCSM_HIBERNATE) begin
         meas_count <= '0;
      end else if (meas_last(meas_count)) begin
         meas_count <= '0;
      end else begin
         meas_count <= meas_count + 32'h00000001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         measure_strobe <= 1'b0;
      end else begin
         measure_strobe <= (state == MCSM_STANDBY)
            && meas_last(meas_count);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         measure_enable <= 1'b0;
         state_code <= RESET_STATE_CODE;
      end else begin
         measure_enable <= (next_state != MCSM_HIBERNATE);
         state_code <= next_state;
      end
   end

   hib_no_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_HIBERNATE |=> !drive_enable && !measure_strobe)
      else $error("drive or measure in hibernate");
   standby_strobe_a: assert property (@(posedge sys_clk) disable iff (reset)
      measure_strobe |-> $past(state) == MCSM_STANDBY)
      else $error("strobe outside standby");
   strobe_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
      measure_strobe |=> !measure_strobe)
      else $error("strobe longer than one cycle");
   drive_active_a: assert property (@(posedge sys_clk) disable iff (reset)
      drive_enable |-> state == MCSM_ACTIVE)
      else $error("drive outside active");
   alert_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
      alert_out |-> !drive_enable && state == MCSM_ALERT)
      else $error("alert with drive on");
   alert_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
      state != MCSM_ALERT ##1 state == MCSM_ALERT |-> !drive_enable && !alert_out)
      else $error("alert raised before drive cut");
   alert_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ALERT && $past(state) == MCSM_ALERT |-> alert_out)
      else $error("alert indication missing");
   active_clean_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(state == MCSM_ACTIVE) |-> !$past(any_protect))
      else $error("active entered under protection");
   protect_alert_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ACTIVE && any_protect && !below_por |=> state == MCSM_ALERT)
      else $error("protection missed in active");
   // alert may only clear through the release timer with every protection down
   alert_protect_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ALERT && any_protect |=> state != MCSM_STANDBY)
      else $error("alert cleared under protection");
   alert_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ALERT && switch_pressed && !below_por |=> state == MCSM_ALERT)
      else $error("alert left while pressed");
   alert_exit_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ALERT && !release_done |=> state != MCSM_STANDBY)
      else $error("alert cleared before release time");
   por_hib_a: assert property (@(posedge sys_clk) disable iff (reset)
      below_por |=> state == MCSM_HIBERNATE)
      else $error("no hibernate below por");
   undervolt_cut_a: assert property (@(posedge sys_clk) disable iff (reset)
      under_voltage_protect |-> !drive_enable)
      else $error("drive on under voltage");
   wake_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_HIBERNATE && !below_por |=> state == MCSM_STANDBY)
      else $error("no wake to standby");
   standby_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_STANDBY && !switch_pressed |=> state != MCSM_ACTIVE)
      else $error("active entered without switch");

   alert_seen_c: cover property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ACTIVE ##1 state == MCSM_ALERT);
   alert_exit_c: cover property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ALERT ##1 state == MCSM_STANDBY);
   active_c: cover property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_STANDBY ##1 state == MCSM_ACTIVE);
   por_c: cover property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ACTIVE ##1 state == MCSM_HIBERNATE);
   protect_hold_c: cover property (@(posedge sys_clk) disable iff (reset)
      state == MCSM_ALERT && release_done && any_protect);
endmodule // mcsm_top

// >>> testbench/mcsm_env_model.sv
// partner: trigger switch, battery pack and protection detectors
// assumes the bench sets levels just after a clock edge
`timescale 1ns/10ps
module mcsm_env_model (
   input wire logic [4:0] want,
   output logic below_por,
   output logic below_discharge,
   output logic over_current,
   output logic over_temp,
   output logic switch_pressed
);
   // levels only: over-current and over-temp come already delayed, as the block expects; the block delays under-voltage itself
   assign {below_por, below_discharge, over_current, over_temp, switch_pressed} = want;
endmodule // mcsm_env_model

// >>> testbench/testbench.sv
// self-checking bench of the operating state machine
// assumes short counts: release 20, under-voltage 10, measurement 8 cycles
`timescale 1ns/10ps
module testbench;
   import mcsm_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic drive_request = 1'b0;
   logic [4:0] want = 5'h00;
   logic bp, bd, oc, ot, sw, de, ao, ms, me, uvp, dq;
   logic [1:0] sc;
   logic [1:0] last = 2'h0;
   logic [1:0] q[$];
   logic [31:0] seed = 32'h6542;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   always #25 sys_clk = ~sys_clk;
   mcsm_env_model mcsm_env_model_i (.want(want), .below_por(bp), .below_discharge(bd),
      .over_current(oc), .over_temp(ot), .switch_pressed(sw));
   mcsm_top #(.RELEASE_CYC(20), .UNDERVOLT_CYC(10), .MEAS_CYC(8)) mcsm_top_i (
      .sys_clk(sys_clk), .reset(reset), .below_por(bp), .below_discharge(bd),
      .over_current(oc),
      .over_temp(ot), .switch_pressed(sw), .drive_request(drive_request),
      .drive_enable(de), .alert_out(ao), .measure_strobe(ms), .measure_enable(me),
      .under_voltage_protect(uvp), .state_code(sc));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         complete_run;
      end
   end
   // random pwm phase reaches the drive gate every cycle
   always @(posedge sys_clk) begin
      #1;
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      drive_request = seed[0];
   end
   always @(posedge sys_clk) begin
      dq = drive_request;
      #2;
      check(de, {31'h0, sc === 2'h2 && dq});
      check(ao, {31'h0, sc === 2'h3 && last === 2'h3});
      if (sc !== last) begin
         check(sc, q.size() > 0 ? q.pop_front() : 2'hX);
      end
      last = sc;
   end
   initial begin
      step(10);
      reset = 1'b0;
      q.push_back(2'h1);
      step(3);
      n = 0;
      repeat (16) begin
         step(1);
         n += ms;
      end
      check(n, 2);
      check(me, 1'b1);
      $display("test standby done");
      want = 5'h01;
      q.push_back(2'h2);
      step(3);
      want = 5'h03;
      q.push_back(2'h3);
      step(3);
      want = 5'h00;
      step(10);
      want = 5'h01;
      step(2);
      want = 5'h00;
      step(20);
      check(sc, 2'h3);
      q.push_back(2'h1);
      step(5);
      $display("test alert done");
      want = 5'h03;
      step(4);
      check(sc, 2'h1);
      want = 5'h08;
      step(8);
      check(uvp, 1'b0);
      step(4);
      check(uvp, 1'b1);
      want = 5'h09;
      step(3);
      check(sc, 2'h1);
      $display("test protect done");
      want = 5'h01;
      q.push_back(2'h2);
      step(3);
      want = {4'h2, seed[0]};
      q.push_back(2'h3);
      step(3);
      want = 5'h04;
      step(25);
      check(sc, 2'h3);
      want = 5'h00;
      q.push_back(2'h1);
      step(2);
      $display("test over-current done");
      want = 5'h01;
      q.push_back(2'h2);
      step(3);
      want = 5'h00;
      q.push_back(2'h1);
      step(2);
      want = 5'h01;
      q.push_back(2'h2);
      step(3);
      want = 5'h11;
      q.push_back(2'h0);
      step(2);
      check(me, 1'b0);
      want = 5'h01;
      q.push_back(2'h1);
      q.push_back(2'h2);
      step(3);
      want = 5'h09;
      q.push_back(2'h3);
      step(9);
      check(sc, 2'h2);
      step(2);
      check(uvp, 1'b1);
      $display("test active exits done");
      want = 5'h10;
      q.push_back(2'h0);
      step(3);
      check(me, 1'b0);
      want = 5'h00;
      q.push_back(2'h1);
      step(3);
      check(q.size(), 0);
      $display("test hibernate done");
      complete_run;
   end
endmodule // testbench
